/* File: design/erf_pkg.sv */
// Shared constants, types and register map of the Ethernet receive filter
package erf_pkg;
	// Register byte offsets on the APB slave
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LINK = 8'h08;
	localparam logic [7:0] REG_IRQ_EN = 8'h0C;
	localparam logic [7:0] REG_HASH_LO = 8'h10;
	localparam logic [7:0] REG_HASH_HI = 8'h14;
	localparam logic [7:0] REG_NODE_LO = 8'h18;
	localparam logic [7:0] REG_NODE_HI = 8'h1C;

	// Mode register fields
	localparam int FM_LO_BIT = 0;
	localparam int FM_HI_BIT = 1;
	localparam int FLAWED_EN_BIT = 2;
	localparam int BUF_EMPTY_BIT = 6;

	// Link control register fields
	localparam int LINK_EN_N_BIT = 7;
	localparam logic LINK_EN_N_RST = 1'b1;

	// Receive status register fields (also header status byte)
	localparam int ST_OVF_BIT = 0;
	localparam int ST_CRC_BIT = 1;
	localparam int ST_ALIGN_BIT = 2;
	localparam int ST_SHORT_BIT = 3;
	localparam int ST_GOOD_BIT = 5;
	localparam int ST_RDERR_BIT = 6;
	localparam int ST_PKT_BIT = 7;

	// Filter mode encodings {filter_mode_hi, filter_mode_lo}
	localparam logic [1:0] FM_REJECT_ALL = 2'b00;
	localparam logic [1:0] FM_NODE_BCAST = 2'b01;
	localparam logic [1:0] FM_NODE_BCAST_HASH = 2'b10;
	localparam logic [1:0] FM_PASS_ALL = 2'b11;

	// Framing and CRC figures
	localparam logic [3:0] SFD_PATTERN = 4'hB;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
	localparam logic [10:0] DA_BYTES = 11'd6;
	localparam logic [10:0] CRC_BYTES = 11'd4;
	localparam logic [10:0] MIN_FRAME = 11'd64;
	localparam logic [2:0] DLY_FULL = 3'd4;
	localparam logic [2:0] FIFO_DEPTH = 3'd4;

	// Receiver sequencing
	typedef enum logic [1:0] {ST_IDLE, ST_PREAMBLE, ST_DATA, ST_FINISH} erf_state_e;

	// Header handed to the buffer controller with each commit
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] spare;
		logic [15:0] len;
	} erf_hdr_s;
endpackage

/* File: design/erf_rx.sv */
// Ethernet receive path: framing, address filter, error checks, APB registers
//
// Functional notes
// - Enable bit low: watch carrier, ready to receive
// - Carrier sense assertion starts a receive attempt
// - Find 1011 preamble end, next bit starts DA
// - Carrier drop before SFD returns to idle, after it ends the frame
// - Classify DA: individual, multicast, broadcast
// - Hash index is top six CRC bits
// - Index splits into table byte and bit
// - Multicast accepted when hash bit set, no errors
// - Hash applies only to multicast addresses
// - Broadcast accepted unless reject-all mode
// - Hash used only in mode binary 10
// - Pass-all, node plus broadcast, node plus hash modes
// - Store only matching error-free packets unless flawed enabled
// - On store: header, clear empty, set arrived, interrupt
// - Last four bytes checked, never written out
// - Errored packet dropped, pointers rewound
// - Kept flawed packet carries errors in header
// - Five receive errors flagged, each interruptible
// - Overflow removes partial packet, keeps earlier ones
// - Small FIFO buffers bytes toward buffer controller
`timescale 1ns/100ps
`default_nettype none

module erf_rx (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_clk_pin,
	input wire logic rx_data_pin,
	input wire logic rx_crs_pin,
	output logic wr_valid,
	output logic [7:0] wr_data,
	input wire logic wr_ready,
	input wire logic buf_full,
	input wire logic buf_drained,
	input wire logic host_rd_empty,
	output logic pkt_commit,
	output logic pkt_discard,
	output erf_pkg::erf_hdr_s pkt_hdr,
	output logic rx_irq
);
	import erf_pkg::*;

	// One serial step of the reflected CRC-32
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
		crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 32'h0000_0000);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers and flags
	logic [1:0] filter_mode;
	logic flawed_en;
	logic buf_empty;
	logic link_enable_n;
	logic [7:0] irq_en;
	logic [63:0] hash_tbl;
	logic [47:0] node_addr;
	logic [7:0] rx_status;
	logic packet_arrived_flag;

	// Input synchronisers and settled levels
	logic [2:0] clk_sync;
	logic [2:0] dat_sync;
	logic [2:0] crs_sync;
	logic clk_lvl;
	logic crs_lvl;
	logic bit_tick;
	logic crs_rise;
	logic crs_fall;

	// Receiver state
	erf_state_e state;
	logic [3:0] pre_sr;
	logic [7:0] sh;
	logic [2:0] bit_cnt;
	logic [10:0] byte_cnt;
	logic [31:0] crc;
	logic [47:0] da;
	logic [7:0] dly [0:3];
	logic [2:0] dly_cnt;
	logic accepting;
	logic addr_ok;
	logic err_ovf;
	logic push_req;
	logic [7:0] push_data;
	logic fin_pulse;
	logic [7:0] fin_err;

	// FIFO
	logic [7:0] fifo_mem [0:3];
	logic [1:0] fifo_wp;
	logic [1:0] fifo_rp;
	logic [2:0] fifo_cnt;

	// Combinational helpers
	logic [7:0] byte_val;
	logic [47:0] da_next;
	logic [31:0] crc_next;
	logic [5:0] hash_idx;
	logic is_mcast;
	logic is_bcast;
	logic is_node;
	logic pass_addr;
	logic apb_wr;
	logic fifo_pop;
	logic drained;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_sync <= 3'h0;
			dat_sync <= 3'h0;
			crs_sync <= 3'h0;
		end else begin
			clk_sync <= {clk_sync[1:0], rx_clk_pin};
			dat_sync <= {dat_sync[1:0], rx_data_pin};
			crs_sync <= {crs_sync[1:0], rx_crs_pin};
		end
	end

	// Settled levels give one-cycle edge events
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_lvl <= 1'b0;
			crs_lvl <= 1'b0;
			bit_tick <= 1'b0;
			crs_rise <= 1'b0;
			crs_fall <= 1'b0;
		end else begin
			bit_tick <= 1'b0;
			crs_rise <= 1'b0;
			crs_fall <= 1'b0;
			if (clk_sync[1] == clk_sync[2] && clk_sync[2] != clk_lvl) begin
				clk_lvl <= clk_sync[2];
				bit_tick <= clk_sync[2];
			end
			if (crs_sync[1] == crs_sync[2] && crs_sync[2] != crs_lvl) begin
				crs_lvl <= crs_sync[2];
				crs_rise <= crs_sync[2];
				crs_fall <= ~crs_sync[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address classification on the byte that completes the DA field
	always_comb begin
		byte_val = {dat_sync[2], sh[7:1]};
		da_next = {byte_val, da[47:8]};
		crc_next = crc_step(crc, dat_sync[2]);
		hash_idx = {crc_next[0], crc_next[1], crc_next[2],
			crc_next[3], crc_next[4], crc_next[5]};
		is_mcast = da_next[0];
		is_bcast = &da_next;
		is_node = ~da_next[0] && (da_next == node_addr);
		case (filter_mode)
			FM_PASS_ALL: pass_addr = 1'b1;
			FM_NODE_BCAST: pass_addr = is_node || is_bcast;
			FM_NODE_BCAST_HASH: pass_addr = is_node || is_bcast
				|| (is_mcast && hash_tbl[hash_idx]);
			default: pass_addr = 1'b0; // Reject all, broadcast too
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver state machine
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			pre_sr <= 4'h0;
			sh <= 8'h00;
			bit_cnt <= 3'd0;
			byte_cnt <= 11'd0;
			crc <= CRC_INIT;
			da <= 48'h0;
			dly_cnt <= 3'd0;
			accepting <= 1'b0;
			addr_ok <= 1'b0;
			err_ovf <= 1'b0;
			push_req <= 1'b0;
			push_data <= 8'h00;
			fin_pulse <= 1'b0;
			fin_err <= 8'h00;
			for (int i = 0; i < 4; i++) begin
				dly[i] <= 8'h00;
			end
		end else begin
			push_req <= 1'b0;
			fin_pulse <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (!link_enable_n && crs_rise) begin
						state <= ST_PREAMBLE;
						pre_sr <= 4'h0;
					end
				end
				ST_PREAMBLE: begin
					if (link_enable_n || crs_fall) begin
						state <= ST_IDLE; // Carrier lost before frame start
					end else if (bit_tick) begin
						pre_sr <= {pre_sr[2:0], dat_sync[2]};
						if ({pre_sr[2:0], dat_sync[2]} == SFD_PATTERN) begin
							state <= ST_DATA;
							bit_cnt <= 3'd0;
							byte_cnt <= 11'd0;
							crc <= CRC_INIT;
							dly_cnt <= 3'd0;
							accepting <= 1'b1;
							addr_ok <= 1'b0;
							err_ovf <= 1'b0;
						end
					end
				end
				ST_DATA: begin
					if (link_enable_n || crs_fall) begin
						// Frame ends on carrier drop or disable; residue, length, alignment and overflow decide fault
						state <= ST_FINISH;
						if (link_enable_n) begin
							accepting <= 1'b0;
						end
						fin_err <= 8'h00;
						fin_err[ST_ALIGN_BIT] <= (bit_cnt != 3'd0);
						fin_err[ST_CRC_BIT] <= (crc != CRC_RESIDUE);
						fin_err[ST_SHORT_BIT] <= (byte_cnt < MIN_FRAME);
						fin_err[ST_OVF_BIT] <= err_ovf;
					end else if (bit_tick) begin
						crc <= crc_next;
						sh <= byte_val;
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == 3'd7) begin
							byte_cnt <= byte_cnt + 11'd1;
							if (byte_cnt < DA_BYTES) begin
								da <= da_next;
							end
							if (byte_cnt == DA_BYTES - 11'd1) begin
								addr_ok <= pass_addr;
								if (!pass_addr) begin
									accepting <= 1'b0; // Rejected: stop feeding buffer
								end
							end
							// Four-byte delay keeps the CRC field out of the buffer
							dly[0] <= byte_val;
							for (int i = 1; i < 4; i++) begin
								dly[i] <= dly[i - 1];
							end
							if (dly_cnt != DLY_FULL) begin
								dly_cnt <= dly_cnt + 3'd1;
							end else if (accepting) begin
								if (buf_full || fifo_cnt == FIFO_DEPTH) begin
									err_ovf <= 1'b1;
									accepting <= 1'b0;
								end else begin
									push_req <= 1'b1;
									push_data <= dly[3];
								end
							end
						end
					end
				end
				ST_FINISH: begin
					// Wait for queued bytes to reach the buffer before deciding
					if (drained && !push_req) begin
						fin_pulse <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Elastic FIFO plus registered output stage toward the buffer
	assign fifo_pop = (fifo_cnt != 3'd0) && (!wr_valid || wr_ready);
	assign drained = (fifo_cnt == 3'd0) && !wr_valid;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fifo_wp <= 2'd0;
			fifo_rp <= 2'd0;
			fifo_cnt <= 3'd0;
			wr_valid <= 1'b0;
			wr_data <= 8'h00;
			for (int i = 0; i < 4; i++) begin
				fifo_mem[i] <= 8'h00;
			end
		end else begin
			if (push_req) begin
				fifo_mem[fifo_wp] <= push_data;
				fifo_wp <= fifo_wp + 2'd1;
			end
			if (fifo_pop) begin
				wr_data <= fifo_mem[fifo_rp];
				fifo_rp <= fifo_rp + 2'd1;
				wr_valid <= 1'b1;
			end else if (wr_ready) begin
				wr_valid <= 1'b0;
			end
			fifo_cnt <= fifo_cnt + {2'd0, push_req} - {2'd0, fifo_pop};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Commit or rewind of the tentatively written packet
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pkt_commit <= 1'b0;
			pkt_discard <= 1'b0;
			pkt_hdr <= '0;
		end else begin
			pkt_commit <= 1'b0;
			pkt_discard <= 1'b0;
			if (fin_pulse) begin
				// Overflow always discards; other faults only when flawed mode is off
				if (addr_ok && accepting && !fin_err[ST_OVF_BIT]
					&& (fin_err == 8'h00 || flawed_en)) begin
					pkt_commit <= 1'b1;
					pkt_hdr.status <= fin_err;
					pkt_hdr.status[ST_GOOD_BIT] <= (fin_err == 8'h00);
					pkt_hdr.spare <= 8'h00;
					pkt_hdr.len <= {5'd0, byte_cnt - CRC_BYTES};
				end else begin
					pkt_discard <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags: hardware set wins over software write-one-clear
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_status <= 8'h00;
			buf_empty <= 1'b1;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (apb_wr && paddr == REG_STATUS && pwdata[i]) begin
					rx_status[i] <= 1'b0;
				end
			end
			// Only a raised error writes, so a same-cycle clear of a quiet bit stands
			for (int i = ST_OVF_BIT; i <= ST_SHORT_BIT; i++) begin
				if (fin_pulse && addr_ok && fin_err[i]) begin
					rx_status[i] <= 1'b1;
				end
			end
			if (host_rd_empty) begin
				rx_status[ST_RDERR_BIT] <= 1'b1;
			end
			if (pkt_commit) begin
				rx_status[ST_PKT_BIT] <= 1'b1;
				buf_empty <= 1'b0;
			end else if (buf_drained) begin
				buf_empty <= 1'b1;
			end
		end
	end

	assign packet_arrived_flag = rx_status[ST_PKT_BIT];

	// Single interrupt line from enabled status bits
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_irq <= 1'b0;
		end else begin
			rx_irq <= |(rx_status & irq_en);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero-wait, answer registered in the setup cycle
	assign apb_wr = psel && penable && pready && pwrite;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= 32'h0000_0000;
				case (paddr)
					REG_MODE: begin
						prdata[FM_HI_BIT:FM_LO_BIT] <= filter_mode;
						prdata[FLAWED_EN_BIT] <= flawed_en;
						prdata[BUF_EMPTY_BIT] <= buf_empty;
					end
					REG_STATUS: prdata[7:0] <= {packet_arrived_flag, rx_status[6:0]};
					REG_LINK: prdata[LINK_EN_N_BIT] <= link_enable_n;
					REG_IRQ_EN: prdata[7:0] <= irq_en;
					REG_HASH_LO: prdata <= hash_tbl[31:0];
					REG_HASH_HI: prdata <= hash_tbl[63:32];
					REG_NODE_LO: prdata <= node_addr[31:0];
					REG_NODE_HI: prdata[15:0] <= node_addr[47:32];
					default: pslverr <= 1'b1; // Unmapped offset
				endcase
			end
		end
	end

	// Software-written control; host keeps hash writes to disabled periods
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			filter_mode <= FM_REJECT_ALL;
			flawed_en <= 1'b0;
			link_enable_n <= LINK_EN_N_RST;
			irq_en <= 8'h00;
			hash_tbl <= 64'h0;
			node_addr <= 48'h0;
		end else if (apb_wr) begin
			case (paddr)
				REG_MODE: begin
					filter_mode <= pwdata[FM_HI_BIT:FM_LO_BIT];
					flawed_en <= pwdata[FLAWED_EN_BIT];
				end
				REG_LINK: link_enable_n <= pwdata[LINK_EN_N_BIT];
				REG_IRQ_EN: irq_en <= pwdata[7:0];
				REG_HASH_LO: hash_tbl[31:0] <= pwdata;
				REG_HASH_HI: hash_tbl[63:32] <= pwdata;
				REG_NODE_LO: node_addr[31:0] <= pwdata;
				REG_NODE_HI: node_addr[47:32] <= pwdata[15:0];
				default: filter_mode <= filter_mode;
			endcase
		end
	end
endmodule // erf_rx

`default_nettype wire

/* File: verif/erf_rx_sva.sv */
// Port checker for the Ethernet receive filter
`timescale 1ns/100ps
`default_nettype none
module erf_rx_sva (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic wr_ready,
	input wire logic pkt_commit,
	input wire logic pkt_discard,
	input wire erf_pkg::erf_hdr_s pkt_hdr
);
	import erf_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	// Buffer side: outcome pulses and byte handshake
	commit_excl_a: assert property (!(pkt_commit && pkt_discard))
		else $error("commit and discard together");
	commit_pulse_a: assert property (pkt_commit |=> !pkt_commit)
		else $error("commit longer than one cycle");
	discard_pulse_a: assert property (pkt_discard |=> !pkt_discard)
		else $error("discard longer than one cycle");
	byte_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
		else $error("byte dropped before taken");
	commit_drained_a: assert property (pkt_commit |-> !wr_valid)
		else $error("commit while bytes pending");
	hdr_hold_a: assert property (pkt_commit |=> $stable(pkt_hdr) [*4])
		else $error("header not held");
	// Header contents tied to the verdict
	good_len_a: assert property (pkt_commit && pkt_hdr.status[ST_GOOD_BIT]
		|-> pkt_hdr.len >= 16'd60 && pkt_hdr.spare == 8'h00)
		else $error("good header with short length");
	good_clean_a: assert property (pkt_commit && pkt_hdr.status[ST_GOOD_BIT]
		|-> pkt_hdr.status[3:0] == 4'h0)
		else $error("good header carries error flags");
	ovf_dropped_a: assert property (pkt_commit |-> !pkt_hdr.status[ST_OVF_BIT])
		else $error("overflowed packet kept");
	// Register bus answers in the cycle after setup
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("register answer late");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("slave error without ready");
	commit_c: cover property (pkt_commit);
	discard_c: cover property (pkt_discard);
	stall_c: cover property (wr_valid && !wr_ready);
	slverr_c: cover property (pslverr);
endmodule // erf_rx_sva
bind erf_rx erf_rx_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .wr_valid(wr_valid),
	.wr_data(wr_data), .wr_ready(wr_ready), .pkt_commit(pkt_commit),
	.pkt_discard(pkt_discard), .pkt_hdr(pkt_hdr));
`default_nettype wire

/* File: verif/erf_buf_model.sv */
// Buffer controller model facing the receive filter
`timescale 1ns/100ps
`default_nettype none
module erf_buf_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	input wire logic pkt_commit,
	input wire logic pkt_discard,
	input wire logic stall,
	input wire logic full_req,
	output logic buf_full,
	input wire logic [10:0] rd_idx,
	output logic [7:0] rd_byte,
	output logic [10:0] base
);
	logic [7:0] mem [0:2047];
	logic [10:0] wp;
	logic [1:0] tick;
	////////////////////////////////////////////////////////////////
	// Stalls take three cycles in four; full only while full_req is driven
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick <= 2'h0;
		end else begin
			tick <= tick + 2'h1;
		end
	end
	assign wr_ready = !stall || tick == 2'h0;
	assign buf_full = full_req;
	assign rd_byte = mem[rd_idx];
	// Tentative pointer: rewound on drop, published on keep
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp <= 11'h0;
			base <= 11'h0;
		end else if (pkt_discard) begin
			wp <= base;
		end else if (pkt_commit) begin
			base <= wp;
		end else if (wr_valid && wr_ready) begin
			mem[wp] <= wr_data;
			wp <= wp + 11'h1;
		end
	end
endmodule // erf_buf_model
`default_nettype wire

/* File: verif/tb_erf_rx.sv */
// Self-checking bench for the Ethernet receive filter
`timescale 1ns/100ps
`default_nettype none
module tb_erf_rx;
	import erf_pkg::*;
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, serr;
	logic rx_clk_pin, rx_data_pin, rx_crs_pin, wr_valid, wr_ready, buf_full, rx_irq;
	logic buf_drained, host_rd_empty, pkt_commit, pkt_discard, stall, full_req;
	logic [7:0] paddr, wr_data, rd_byte;
	logic [31:0] pwdata, prdata, rd, rnd;
	logic [10:0] rd_idx, base;
	logic [47:0] node, mc1, mc2;
	logic [63:0] hash;
	logic [7:0] frm [0:127];
	erf_hdr_s pkt_hdr;
	int fails, compares;
	erf_rx u_dut (.*);
	erf_buf_model u_buf (.*);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("Counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One APB transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			summarize();
		end
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle so a following call never retoggles the strobes at once
		@(posedge ref_clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd & m, e);
	endtask
	////////////////////////////////////////////////////////////////
	// Expectation helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? CRC_POLY : 32'h0);
		return c;
	endfunction
	function automatic logic [5:0] hidx(input logic [47:0] da);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 6; i++) c = crc8(c, da[8*i +: 8]);
		return {c[0], c[1], c[2], c[3], c[4], c[5]};
	endfunction
	function automatic logic passes(input logic [1:0] m, input logic [47:0] da);
		if (m == FM_REJECT_ALL) return 1'b0;
		if (m == FM_PASS_ALL || da == node || &da) return 1'b1;
		return m == FM_NODE_BCAST_HASH && da[0] && hash[hidx(da)];
	endfunction
	// Half bit of five clocks; data settles before the recovered clock rises
	task automatic bit_out(input logic b);
		rx_data_pin <= b;
		rx_clk_pin <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rx_clk_pin <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////
	// One frame: build, send, then judge outcome, header, bytes and status
	task automatic run_case(input logic [1:0] m, input logic [47:0] da, input logic bad,
		input logic fl, input int len, input logic ovf);
		logic [31:0] c;
		logic [10:0] bs;
		logic p, cm, shrt;
		int n;
		apb(1'b1, REG_MODE, {29'h0, fl, m});
		c = CRC_INIT;
		for (int i = 0; i < len - 4; i++) begin
			rnd = lfsr(rnd);
			frm[i] = (i < 6) ? da[8*i +: 8] : rnd[7:0];
			c = crc8(c, frm[i]);
		end
		c = ~c ^ {31'h0, bad};
		for (int i = 0; i < 4; i++) frm[len-4+i] = c[8*i +: 8];
		p = passes(m, da);
		shrt = len < MIN_FRAME;
		cm = p && !ovf && (fl || (!bad && !shrt));
		stall <= rnd[9];
		full_req <= ovf;
		bs = base;
		rx_crs_pin <= 1'b1;
		for (int i = 0; i < 16; i++) bit_out(!i[0] || i == 15);
		for (int i = 0; i < len; i++) for (int j = 0; j < 8; j++) bit_out(frm[i][j]);
		rx_crs_pin <= 1'b0;
		rx_data_pin <= ~rx_data_pin;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pkt_commit !== 1'b1 && pkt_discard !== 1'b1 && n < 400);
		if (n >= 400) begin
			fails++;
			summarize();
		end
		check(32'(pkt_commit), 32'(cm));
		full_req <= 1'b0;
		if (cm) begin
			check(32'(pkt_hdr.len), len - 4);
			check(32'(pkt_hdr.status[5:0]),
				32'({!bad && !shrt, 1'b0, shrt, 1'b0, bad, 1'b0}));
			for (int i = 0; i < len - 4; i++) begin
				rd_idx <= bs + 11'(i);
				@(posedge ref_clk);
				check(32'(rd_byte), 32'(frm[i]));
			end
			rdchk(REG_MODE, 32'h40, 32'h0);
		end
		rdchk(REG_STATUS, 32'h8F,
			32'({cm, 3'h0, p && shrt, 1'b0, p && bad, p && ovf}));
		check(32'(rx_irq), 32'(cm));
		apb(1'b1, REG_STATUS, 32'hFF);
		repeat (2) @(posedge ref_clk);
		check(32'(rx_irq), 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, rx_clk_pin, rx_data_pin, rx_crs_pin} = 6'h0;
		{buf_drained, host_rd_empty, stall, full_req} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		rd_idx = 11'h0;
		rnd = 32'h69fa;
		node = 48'h5634_1290_AB02;
		mc1 = 48'h0F00_5E00_0001;
		hash = 64'h0;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rdchk(REG_LINK, 32'hFF, 32'h80);
		rdchk(REG_MODE, 32'h40, 32'h40);
		rdchk(8'h40, 32'hFFFF_FFFF, 32'h0);
		check(32'(serr), 32'h1);
		mc2 = mc1;
		while (hidx(mc2) == hidx(mc1)) mc2 = mc2 + 48'h100;
		hash[hidx(mc1)] = 1'b1;
		// Tables are loaded while the receiver is still off
		apb(1'b1, REG_NODE_LO, node[31:0]);
		apb(1'b1, REG_NODE_HI, {16'h0, node[47:32]});
		apb(1'b1, REG_HASH_LO, hash[31:0]);
		apb(1'b1, REG_HASH_HI, hash[63:32]);
		apb(1'b1, REG_IRQ_EN, 32'h80);
		apb(1'b1, REG_LINK, 32'h0);
		for (int m = 0; m < 4; m++) begin
			run_case(2'(m), {48{1'b1}}, 1'b0, 1'b0, 64, 1'b0);
		end
		run_case(FM_NODE_BCAST, node, 1'b0, 1'b0, 64, 1'b0);
		run_case(FM_NODE_BCAST, node ^ 48'h4, 1'b0, 1'b0, 64, 1'b0);
		run_case(FM_NODE_BCAST_HASH, mc1, 1'b0, 1'b0, 64, 1'b0);
		run_case(FM_NODE_BCAST_HASH, mc2, 1'b0, 1'b0, 64, 1'b0);
		run_case(FM_NODE_BCAST, mc1, 1'b0, 1'b0, 64, 1'b0);
		run_case(FM_NODE_BCAST_HASH, node, 1'b1, 1'b0, 64, 1'b0);
		run_case(FM_PASS_ALL, mc2, 1'b1, 1'b1, 64, 1'b0);
		run_case(FM_PASS_ALL, node, 1'b0, 1'b1, 20, 1'b0);
		run_case(FM_PASS_ALL, node, 1'b0, 1'b1, 64, 1'b1);
		host_rd_empty <= 1'b1;
		@(posedge ref_clk);
		host_rd_empty <= 1'b0;
		buf_drained <= 1'b1;
		@(posedge ref_clk);
		buf_drained <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rdchk(REG_STATUS, 32'h40, 32'h40);
		rdchk(REG_MODE, 32'h40, 32'h40);
		summarize();
	end
endmodule // tb_erf_rx
`default_nettype wire
